//--- owb_window_blank.sv
// Purpose: Solid space, scan scaling, window and blank for the OSD output path.
// Assumes: Pixel stream, sync and retrace inputs are synchronous to ref_clk_in.
// Notes: The pixel stream is delayed by one cell so that the right neighbour is known.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module owb_window_blank #(
  parameter int unsigned CELL_DOTS = owb_pkg::CELL_DOTS
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [owb_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [owb_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [owb_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic h_retrace_in,
  input wire logic v_retrace_in,
  input wire owb_pkg::owb_pix_type pix_in,
  output owb_pkg::owb_out_type pix_out,
  output logic [owb_pkg::POS_W-1:0] v_start_line_out,
  output logic [3:0] dot_height_half_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl3_reg;
  logic [7:0] top_bound_lo_reg;
  logic [7:0] top_bound_hi_reg;
  logic [7:0] bottom_bound_lo_reg;
  logic [7:0] bottom_bound_hi_reg;
  logic [7:0] left_bound_lo_reg;
  logic [7:0] left_bound_hi_reg;
  logic [7:0] right_bound_lo_reg;
  logic [7:0] right_bound_hi_reg;
  logic [7:0] vpos_reg;
  logic [1:0] dot_size_reg;
  logic [owb_pkg::POS_W-1:0] line_cnt_reg;
  logic [owb_pkg::POS_W-1:0] dot_cnt_reg;

  wire wr_en = ce_in & reg_wr_in;
  wire wr_c1 = wr_en & (reg_addr_in == owb_pkg::OFS_CTRL1);
  wire wr_c2 = wr_en & (reg_addr_in == owb_pkg::OFS_CTRL2);
  wire wr_c3 = wr_en & (reg_addr_in == owb_pkg::OFS_CTRL3);
  wire wr_tlo = wr_en & (reg_addr_in == owb_pkg::OFS_TOP_LO);
  wire wr_thi = wr_en & (reg_addr_in == owb_pkg::OFS_TOP_HI);
  wire wr_blo = wr_en & (reg_addr_in == owb_pkg::OFS_BOTTOM_LO);
  wire wr_bhi = wr_en & (reg_addr_in == owb_pkg::OFS_BOTTOM_HI);
  wire wr_llo = wr_en & (reg_addr_in == owb_pkg::OFS_LEFT_LO);
  wire wr_lhi = wr_en & (reg_addr_in == owb_pkg::OFS_LEFT_HI);
  wire wr_rlo = wr_en & (reg_addr_in == owb_pkg::OFS_RIGHT_LO);
  wire wr_rhi = wr_en & (reg_addr_in == owb_pkg::OFS_RIGHT_HI);
  wire wr_vpos = wr_en & (reg_addr_in == owb_pkg::OFS_VPOS);
  wire wr_dsz = wr_en & (reg_addr_in == owb_pkg::OFS_DOT_SIZE);

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl1_reg <= owb_pkg::REG_RESET;
      ctrl2_reg <= owb_pkg::REG_RESET;
      ctrl3_reg <= owb_pkg::REG_RESET;
      top_bound_lo_reg <= owb_pkg::REG_RESET;
      top_bound_hi_reg <= owb_pkg::REG_RESET;
      bottom_bound_lo_reg <= owb_pkg::REG_RESET;
      bottom_bound_hi_reg <= owb_pkg::REG_RESET;
      left_bound_lo_reg <= owb_pkg::REG_RESET;
      left_bound_hi_reg <= owb_pkg::REG_RESET;
      right_bound_lo_reg <= owb_pkg::REG_RESET;
      right_bound_hi_reg <= owb_pkg::REG_RESET;
      vpos_reg <= owb_pkg::REG_RESET;
      dot_size_reg <= 2'h0;
    end
    else
    begin
      if (wr_c1) ctrl1_reg <= reg_wdata_in;
      if (wr_c2) ctrl2_reg <= reg_wdata_in;
      if (wr_c3) ctrl3_reg <= reg_wdata_in;
      if (wr_tlo) top_bound_lo_reg <= reg_wdata_in;
      if (wr_thi) top_bound_hi_reg <= reg_wdata_in;
      if (wr_blo) bottom_bound_lo_reg <= reg_wdata_in;
      if (wr_bhi) bottom_bound_hi_reg <= reg_wdata_in;
      if (wr_llo) left_bound_lo_reg <= reg_wdata_in;
      if (wr_lhi) left_bound_hi_reg <= reg_wdata_in;
      if (wr_rlo) right_bound_lo_reg <= reg_wdata_in;
      if (wr_rhi) right_bound_hi_reg <= reg_wdata_in;
      if (wr_vpos) vpos_reg <= reg_wdata_in;
      if (wr_dsz) dot_size_reg <= reg_wdata_in[1:0];
    end
  end

  // Unmapped offsets read as zero; the line counter shows live raster position.
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr_in)
      owb_pkg::OFS_CTRL1: rd_mux = ctrl1_reg;
      owb_pkg::OFS_CTRL2: rd_mux = ctrl2_reg;
      owb_pkg::OFS_CTRL3: rd_mux = ctrl3_reg;
      owb_pkg::OFS_TOP_LO: rd_mux = top_bound_lo_reg;
      owb_pkg::OFS_TOP_HI: rd_mux = top_bound_hi_reg;
      owb_pkg::OFS_BOTTOM_LO: rd_mux = bottom_bound_lo_reg;
      owb_pkg::OFS_BOTTOM_HI: rd_mux = bottom_bound_hi_reg;
      owb_pkg::OFS_LEFT_LO: rd_mux = left_bound_lo_reg;
      owb_pkg::OFS_LEFT_HI: rd_mux = left_bound_hi_reg;
      owb_pkg::OFS_RIGHT_LO: rd_mux = right_bound_lo_reg;
      owb_pkg::OFS_RIGHT_HI: rd_mux = right_bound_hi_reg;
      owb_pkg::OFS_LINE_LO: rd_mux = line_cnt_reg[7:0];
      owb_pkg::OFS_LINE_HI: rd_mux = line_cnt_reg[15:8];
      owb_pkg::OFS_VPOS: rd_mux = vpos_reg;
      owb_pkg::OFS_DOT_SIZE: rd_mux = {6'h00, dot_size_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      reg_rdata_out <= 8'h00;
    else if (ce_in)
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Raster position counters, measured from sync edges.

  logic hsync_d_reg;
  logic vsync_d_reg;
  wire h_edge = hsync_in & ~hsync_d_reg;
  wire v_edge = vsync_in & ~vsync_d_reg;
  wire line_full = &line_cnt_reg;
  wire dot_full = &dot_cnt_reg;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hsync_d_reg <= 1'b0;
      vsync_d_reg <= 1'b0;
      line_cnt_reg <= 16'h0000;
      dot_cnt_reg <= 16'h0000;
    end
    else if (ce_in)
    begin
      hsync_d_reg <= hsync_in;
      vsync_d_reg <= vsync_in;
      if (v_edge)
        line_cnt_reg <= 16'h0000;
      else if (h_edge && !line_full)
        line_cnt_reg <= line_cnt_reg + 16'h0001;
      if (h_edge)
        dot_cnt_reg <= 16'h0000;
      else if (!dot_full)
        dot_cnt_reg <= dot_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan mode scaling.

  wire bi_scan = ctrl1_reg[owb_pkg::C1_BI_SCAN]; // see [RQ6]
  logic [3:0] height_norm;
  always_comb
  begin
    unique case (dot_size_reg)
      2'h0: height_norm = 4'h1;
      2'h1: height_norm = 4'h2;
      2'h2: height_norm = 4'h4;
      default: height_norm = 4'h6;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      v_start_line_out <= 16'h0000;
      dot_height_half_out <= 4'h0;
    end
    else if (ce_in)
    begin
      v_start_line_out <= {7'h00, vpos_reg, 1'b0} >> !bi_scan; // see [RQ7]
      dot_height_half_out <= height_norm << bi_scan; // see [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cell delay line and neighbour tracking for solid space.

  owb_pkg::owb_pix_type dly_mem [CELL_DOTS];
  owb_pkg::owb_pix_type dly_pix;

  always_ff @(posedge ref_clk_in)
  begin
    if (ce_in)
    begin
      for (int i = CELL_DOTS - 1; i > 0; i--)
        dly_mem[i] <= dly_mem[i-1];
      dly_mem[0] <= pix_in;
    end
  end
  assign dly_pix = dly_mem[CELL_DOTS-1];

  logic nb_in_reg;
  logic nb_mid_reg;
  logic nb_prev_reg;
  wire nb_new = pix_in.active & (pix_in.mode == owb_pkg::MODE_CAPTION)
    & (pix_in.code != owb_pkg::BLANK_CODE);
  wire nb_in_next = pix_in.cell_first ? nb_new : nb_in_reg;
  wire nb_mid_next = pix_in.cell_first ? nb_in_reg : nb_mid_reg;
  wire nb_prev_next = pix_in.cell_first ? nb_mid_reg : nb_prev_reg;

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nb_in_reg <= 1'b0;
      nb_mid_reg <= 1'b0;
      nb_prev_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      nb_in_reg <= nb_in_next;
      nb_mid_reg <= nb_mid_next;
      nb_prev_reg <= nb_prev_next;
    end
  end

  // The delayed dot belongs to the middle cell; its neighbours are either side.
  wire solid_en = ctrl1_reg[owb_pkg::C1_SOLID_EN]; // see [RQ2]
  wire solid_to_b = ctrl2_reg[owb_pkg::C2_SOLID_TO_B]; // see [RQ3]
  wire solid_area = solid_en & (dly_pix.mode == owb_pkg::MODE_CAPTION)
    & (nb_prev_next | nb_mid_next | nb_in_next); // see [RQ1]
  wire solid_a = solid_area & ~solid_to_b;
  wire solid_b = solid_area & solid_to_b;

  ////////////////////////////////////////////////////////////////////////////
  // Window and blank geometry.

  wire [15:0] top_val = {top_bound_hi_reg, top_bound_lo_reg}; // see [RQ14]
  wire [15:0] bottom_val = {bottom_bound_hi_reg, bottom_bound_lo_reg};
  wire [15:0] left_val = {left_bound_hi_reg, left_bound_lo_reg}; // see [RQ15]
  wire [15:0] right_val = {right_bound_hi_reg, right_bound_lo_reg};

  // Bounds are assumed ordered by software, so no swap logic is spent here. see [RQ16]
  wire v_inside = (line_cnt_reg >= top_val) & (line_cnt_reg < bottom_val); // see [RQ22]
  wire h_inside = (dot_cnt_reg >= left_val) & (dot_cnt_reg < right_val);

  wire vert_on = ctrl1_reg[owb_pkg::C1_VERT_ON]; // see [RQ9]
  wire vert_blank_sel = ctrl2_reg[owb_pkg::C2_VERT_BLANK];
  wire horz_on = ctrl2_reg[owb_pkg::C2_HORZ_ON]; // see [RQ10]
  wire horz_blank_sel = ctrl2_reg[owb_pkg::C2_HORZ_BLANK];

  wire win_out = (vert_on & ~vert_blank_sel & ~v_inside)
    | (horz_on & ~horz_blank_sel & ~h_inside); // see [RQ13]
  wire [2:0] win_modes = ctrl3_reg[owb_pkg::C3_WIN_MODE_LSB +: 3];
  wire mode_win = win_modes[dly_pix.mode]; // see [RQ11]
  wire osd_cut = win_out & mode_win;

  wire retrace = h_retrace_in | v_retrace_in;
  wire blank_area = ((vert_on & vert_blank_sel & ~v_inside)
    | (horz_on & horz_blank_sel & ~h_inside)) & ~retrace; // see [RQ18] [RQ20] [RQ22]

  ////////////////////////////////////////////////////////////////////////////
  // Output combination.

  logic luma_a_next;
  logic luma_b_next;
  logic [3:0] pal_next;
  always_comb
  begin
    luma_a_next = solid_en ? (solid_a | (solid_to_b & dly_pix.luma_a_src))
      : dly_pix.luma_a_src;
    luma_b_next = dly_pix.char_out_b_attr & ((dly_pix.active & (dly_pix.font
      | dly_pix.bgnd)) | solid_b); // see [RQ5]
    if (dly_pix.font)
      pal_next = dly_pix.fg_pal;
    else if (dly_pix.bgnd)
      pal_next = solid_a ? owb_pkg::SOLID_BG_PAL : dly_pix.bg_pal; // see [RQ4]
    else
      pal_next = 4'h0;
  end

  // Blank is an extra drive on output A; the OSD itself stays visible under it.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pix_out <= '0;
    else if (ce_in)
    begin
      pix_out.osd_en <= (dly_pix.active | solid_area) & ~osd_cut; // see [RQ19]
      pix_out.luma_ctrl_out_a <= (luma_a_next & ~osd_cut) | blank_area; // see [RQ18]
      pix_out.luma_ctrl_out_b <= luma_b_next & ~win_out; // see [RQ12]
      pix_out.raster_en <= ~blank_area; // see [RQ19]
      pix_out.pal <= osd_cut ? 4'h0 : pal_next;
    end
  end

endmodule

`default_nettype wire

//--- owb_pkg.sv
// Purpose: Shared constants and types for the OSD window, blank and solid-space block.
// Assumes: 8-bit register port, one dot clock, sync inputs synchronous to that clock.
// Notes: Register offsets are word indices on the plain register port.
//
// How it works
// [RQ1] Caption nonblank cells and neighbours get solid space
// [RQ2] Control 1 bit 4 enables solid space
// [RQ3] Control 2 bit 3 routes solid space A/B
// [RQ4] Solid space on A forces background palette 8
// [RQ5] Output B follows attribute, plus routed solid space
// [RQ6] Control 1 bit 1 picks normal or bi-scan
// [RQ7] Start line is position times one/two lines
// [RQ8] Dot heights half,1,2,3 lines; bi-scan doubles
// [RQ9] Vertical on-switch ctrl1 bit5, kind ctrl2 bit6
// [RQ10] Horizontal on-switch ctrl2 bit4, kind ctrl2 bit5
// [RQ11] Control 3 bits 5..7 pick windowed modes
// [RQ12] Output B windowed in every mode
// [RQ13] Window suppresses OSD outside boundary rectangle
// [RQ14] Top/bottom are low plus 256 times high, lines
// [RQ15] Left/right are low plus 256 times high, dots
// [RQ16] Software keeps left below right, top below bottom
// [RQ17] Software avoids tiny top and zero left values
// [RQ18] Blank drives output A outside borders
// [RQ19] OSD output still shown inside blanked area
// [RQ20] No blank during retrace intervals
// [RQ21] Software avoids vertical blank with display off
// [RQ22] Blank covers before top/left and from bottom/right
package owb_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned POS_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL3 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TOP_LO = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_TOP_HI = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_BOTTOM_LO = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_BOTTOM_HI = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_LEFT_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_LEFT_HI = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_RIGHT_LO = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_RIGHT_HI = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_LINE_LO = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_LINE_HI = 4'hC;
  localparam logic [ADDR_W-1:0] OFS_VPOS = 4'hD;
  localparam logic [ADDR_W-1:0] OFS_DOT_SIZE = 4'hE;

  localparam int unsigned C1_DISP_ALL = 0;
  localparam int unsigned C1_BI_SCAN = 1;
  localparam int unsigned C1_SOLID_EN = 4;
  localparam int unsigned C1_VERT_ON = 5;
  localparam int unsigned C2_SOLID_TO_B = 3;
  localparam int unsigned C2_HORZ_ON = 4;
  localparam int unsigned C2_HORZ_BLANK = 5;
  localparam int unsigned C2_VERT_BLANK = 6;
  localparam int unsigned C3_WIN_MODE_LSB = 5;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [7:0] BLANK_CODE = 8'h09;
  localparam logic [3:0] SOLID_BG_PAL = 4'h8;
  localparam int unsigned CELL_DOTS = 12;

  typedef enum logic [1:0]
  {
    MODE_CAPTION = 2'h0,
    MODE_CHAR_OSD = 2'h1,
    MODE_DOT_GRAPHIC = 2'h2
  } owb_mode_type;

  // One dot of the character pipeline.
  typedef struct packed
  {
    logic active;
    logic cell_first;
    logic [7:0] code;
    owb_mode_type mode;
    logic font;
    logic bgnd;
    logic luma_a_src;
    logic char_out_b_attr;
    logic [3:0] fg_pal;
    logic [3:0] bg_pal;
  } owb_pix_type;

  // One dot as it leaves for the pins.
  typedef struct packed
  {
    logic osd_en;
    logic luma_ctrl_out_a;
    logic luma_ctrl_out_b;
    logic raster_en;
    logic [3:0] pal;
  } owb_out_type;

endpackage

//--- owb_window_blank_properties.sv
// Purpose: Port-level temporal checks for the window, blank and scan block.
// Assumes: Only top-level ports are visible; a mirror follows register writes.
// Notes: Pixel checks wait until the delay line has been refilled after reset.
`timescale 1ns/1ps
`default_nettype none
module owb_window_blank_chk #(
  parameter int unsigned CELL_DOTS = 12
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [owb_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [owb_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [owb_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic h_retrace_in,
  input wire logic v_retrace_in,
  input wire owb_pkg::owb_pix_type pix_in,
  input wire owb_pkg::owb_out_type pix_out,
  input wire logic [owb_pkg::POS_W-1:0] v_start_line_out,
  input wire logic [3:0] dot_height_half_out
);
  logic [7:0] m_reg [16];
  logic [7:0] rd_exp_reg;
  logic [1:0] quiet_reg;
  logic [4:0] age_reg;
  logic wr_ok;
  logic [3:0] dh_base;
  assign wr_ok = ce_in && reg_wr_in && (reg_addr_in < owb_pkg::OFS_LINE_LO
    || reg_addr_in == owb_pkg::OFS_VPOS || reg_addr_in == owb_pkg::OFS_DOT_SIZE);
  assign dh_base = (m_reg[14][1:0] == 2'h3) ? 4'h6 : (4'h1 << m_reg[14][1:0]);
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      m_reg <= '{default: 8'h00};
      rd_exp_reg <= 8'h00;
      quiet_reg <= 2'h0;
      age_reg <= 5'h00;
    end
    else if (ce_in)
    begin
      if (wr_ok)
        m_reg[reg_addr_in] <= reg_wdata_in;
      rd_exp_reg <= m_reg[reg_addr_in];
      quiet_reg <= reg_wr_in ? 2'h0 : quiet_reg + 2'(quiet_reg != 2'h3);
      age_reg <= age_reg + 5'(age_reg != 5'h1F);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_read;
    ce_in && reg_rd_in && reg_addr_in != owb_pkg::OFS_LINE_LO
      && reg_addr_in != owb_pkg::OFS_LINE_HI;
  endsequence
  // Display on, every boundary function off, and no write for three cycles.
  sequence s_plain;
    quiet_reg == 2'h3 && age_reg == 5'h1F && m_reg[0][0] && !m_reg[0][5] && !m_reg[1][4];
  endsequence
  chk_read_value:
    assert property (s_read |=> reg_rdata_out == rd_exp_reg) else $error("Read data wrong.");
  chk_read_idle:
    assert property ((age_reg != 5'h00 && $past(ce_in) && !$past(reg_rd_in))
      |-> reg_rdata_out == 8'h00) else $error("Read data not cleared.");
  chk_start_line:
    assert property (quiet_reg == 2'h3 |-> v_start_line_out
      == (m_reg[0][1] ? {7'h00, m_reg[13], 1'b0} : {8'h00, m_reg[13]}))
      else $error("Start line wrong.");
  chk_dot_height:
    assert property ($rose(quiet_reg == 2'h3) |-> (dot_height_half_out
      == (m_reg[0][1] ? dh_base << 1 : dh_base)) [*2]) else $error("Dot height wrong.");
  chk_blank_drives_a:
    assert property ((age_reg == 5'h1F && !pix_out.raster_en) |-> pix_out.luma_ctrl_out_a)
      else $error("Blank without output A.");
  chk_retrace_quiet:
    assert property ((age_reg == 5'h1F && $past(h_retrace_in || v_retrace_in))
      |-> pix_out.raster_en) else $error("Blank during retrace.");
  chk_blank_off:
    assert property (s_plain |-> pix_out.raster_en) else $error("Blank while disabled.");
  chk_osd_passes:
    assert property (s_plain |-> pix_out.osd_en == $past(pix_in.active, CELL_DOTS + 1))
      else $error("OSD lost without window.");
endmodule
bind owb_window_blank owb_window_blank_chk #(.CELL_DOTS(CELL_DOTS)) i_owb_window_blank_chk (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .h_retrace_in(h_retrace_in), .v_retrace_in(v_retrace_in),
  .pix_in(pix_in), .pix_out(pix_out), .v_start_line_out(v_start_line_out),
  .dot_height_half_out(dot_height_half_out));
`default_nettype wire

//--- owb_crt_model.sv
// Purpose: Sync and character-cell source standing in for the video path.
// Assumes: Lines of 32 dots, frames of 8 lines, retrace at line and frame end.
// Notes: Cell 8 of each line carries a visible code, all others the blank code.
`timescale 1ns/1ps
`default_nettype none
module owb_crt_model #(
  parameter int unsigned CELL_DOTS = 2
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire owb_pkg::owb_pix_type tmpl_in,
  output logic hsync_out,
  output logic vsync_out,
  output logic h_retrace_out,
  output logic v_retrace_out,
  output owb_pkg::owb_pix_type pix_out
);
  logic [4:0] dot_reg;
  logic [2:0] line_reg;
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      dot_reg <= 5'h00;
      line_reg <= 3'h0;
    end
    else
    begin
      dot_reg <= dot_reg + 5'h01;
      line_reg <= line_reg + 3'(dot_reg == 5'h1F);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  assign hsync_out = dot_reg < 5'h02;
  assign vsync_out = line_reg == 3'h0;
  assign h_retrace_out = dot_reg > 5'h1B;
  assign v_retrace_out = line_reg == 3'h7;
  always_comb
  begin
    pix_out = tmpl_in;
    pix_out.cell_first = (32'(dot_reg) % CELL_DOTS) == 0;
    pix_out.code = (32'(dot_reg) / CELL_DOTS == 8) ? 8'h41 : owb_pkg::BLANK_CODE;
  end
endmodule
`default_nettype wire

//--- test_owb_window_blank.sv
// Purpose: Register, scan, blank, window and solid-space tests.
// Assumes: Small cell width; counts over one whole frame are phase independent.
// Notes: Bounds are top 2, bottom 4, left 4, right 8.
`timescale 1ns/1ps
`default_nettype none
module test_owb_window_blank;
  localparam int unsigned CD = 2;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rdata;
  logic hs, vs, hr, vr;
  logic [15:0] vstart;
  logic [3:0] dh;
  owb_pkg::owb_pix_type pix;
  owb_pkg::owb_pix_type tmpl = '0;
  owb_pkg::owb_out_type po;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int ht [4] = '{1, 2, 4, 6};
  logic [7:0] bnd [8] = '{8'h02, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00};
  owb_window_blank #(.CELL_DOTS(CD)) i_owb_window_blank (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .ce_in(ce), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .hsync_in(hs), .vsync_in(vs),
    .h_retrace_in(hr), .v_retrace_in(vr), .pix_in(pix), .pix_out(po),
    .v_start_line_out(vstart), .dot_height_half_out(dh));
  owb_crt_model #(.CELL_DOTS(CD)) i_owb_crt_model (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .tmpl_in(tmpl), .hsync_out(hs), .vsync_out(vs),
    .h_retrace_out(hr), .v_retrace_out(vr), .pix_out(pix));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmpv(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A negative expectation means the count is not judged in that scenario.
  task automatic cmpn(input string nm, input int e, input int g);
    if (e >= 0)
      cmpv(nm, 16'(e), 16'(g));
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    cmpv("reg_rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic pt(input logic attr, input logic font, input logic bgnd,
    input owb_pkg::owb_mode_type m);
    @(posedge ref_clk_in);
    tmpl.char_out_b_attr <= attr;
    tmpl.font <= font;
    tmpl.bgnd <= bgnd;
    tmpl.mode <= m;
  endtask
  function automatic logic [7:0] dv(input int a);
    return (a == 14) ? 8'h02 : {4'(a), ~4'(a)};
  endfunction
  // Counts run over exactly one 256-dot frame, so the pipeline phase drops out.
  task automatic run(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
    input int e_r, input int e_o, input int e_a, input int e_b, input int e_p);
    int n [5] = '{default: 0};
    wr_reg(owb_pkg::OFS_CTRL1, c1);
    wr_reg(owb_pkg::OFS_CTRL2, c2);
    wr_reg(owb_pkg::OFS_CTRL3, c3);
    repeat (64) @(posedge ref_clk_in);
    repeat (256)
    begin
      @(posedge ref_clk_in);
      #1;
      n[0] += int'(po.raster_en === 1'b1);
      n[1] += int'(po.osd_en === 1'b1);
      n[2] += int'(po.luma_ctrl_out_a === 1'b1);
      n[3] += int'(po.luma_ctrl_out_b === 1'b1);
      n[4] += int'(po.pal === 4'h8);
    end
    cmpn("raster_en count", e_r, n[0]);
    cmpn("osd_en count", e_o, n[1]);
    cmpn("luma_ctrl_out_a count", e_a, n[2]);
    cmpn("luma_ctrl_out_b count", e_b, n[3]);
    cmpn("palette 8 count", e_p, n[4]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    tmpl.active = 1'b1;
    tmpl.bg_pal = 4'h3;
    repeat (12) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    for (int a = 0; a < 16; a++)
      if (a != 11 && a != 12)
        wr_reg(4'(a), dv(a));
    for (int a = 0; a < 16; a++)
      if (a != 11 && a != 12)
        rd_reg(4'(a), (a == 15) ? 8'h00 : dv(a));
    // A write strobe in a cycle with the clock enable low must be dropped.
    @(posedge ref_clk_in);
    addr <= owb_pkg::OFS_VPOS;
    wdata <= 8'h77;
    wr <= 1'b1;
    ce <= 1'b0;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    ce <= 1'b1;
    rd_reg(owb_pkg::OFS_VPOS, dv(13));
    for (int i = 0; i < 8; i++)
      wr_reg(4'(owb_pkg::OFS_TOP_LO + 4'(i)), bnd[i]);
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(owb_pkg::OFS_CTRL1, {6'h00, i[2], 1'b0});
      wr_reg(owb_pkg::OFS_DOT_SIZE, {6'h00, i[1:0]});
      wr_reg(owb_pkg::OFS_VPOS, 8'h05);
      repeat (4) @(posedge ref_clk_in);
      #1;
      cmpv("v_start_line", 16'(5 * (i[2] + 1)), vstart);
      cmpv("dot_height", 16'(ht[i[1:0]] * (i[2] + 1)), {12'h000, dh});
    end
    run(8'h01, 8'h30, 8'h00, 88, 256, 168, 0, -1);
    run(8'h21, 8'h40, 8'h00, 116, 256, 140, 0, -1);
    pt(1'b1, 1'b1, 1'b0, owb_pkg::MODE_CAPTION);
    run(8'h01, 8'h10, 8'h20, 256, 32, 0, 32, -1);
    run(8'h01, 8'h10, 8'h40, 256, 256, 0, 32, -1);
    run(8'h21, 8'h00, 8'h20, 256, 64, 0, 64, -1);
    pt(1'b1, 1'b1, 1'b0, owb_pkg::MODE_CHAR_OSD);
    run(8'h01, 8'h10, 8'h40, 256, 32, 0, 32, -1);
    pt(1'b1, 1'b1, 1'b0, owb_pkg::MODE_DOT_GRAPHIC);
    run(8'h01, 8'h10, 8'h80, 256, 32, 0, 32, -1);
    pt(1'b0, 1'b0, 1'b1, owb_pkg::MODE_CAPTION);
    run(8'h11, 8'h00, 8'h00, 256, 256, 48, 0, 48);
    run(8'h01, 8'h00, 8'h00, 256, 256, 0, 0, 0);
    pt(1'b1, 1'b0, 1'b0, owb_pkg::MODE_CAPTION);
    run(8'h11, 8'h08, 8'h00, 256, 256, 0, 48, -1);
    results();
  end
endmodule
`default_nettype wire
